// *** i2c_port_pkg.sv ***
// Constants and types shared by the packet port and its buffer
package i2c_port_pkg;
    // Word address functions
    localparam logic [7:0] WA_RESET   = 8'h00;
    localparam logic [7:0] WA_SLEEP   = 8'h01;
    localparam logic [7:0] WA_IDLE    = 8'h02;
    localparam logic [7:0] WA_COMMAND = 8'h03;
    // Buffer sizes
    localparam int         IN_BYTES   = 84;
    localparam logic [6:0] IN_LIMIT   = 7'h54;
    localparam int         OUT_BYTES  = 35;
    localparam int         FIFO_DEPTH = 8;
    localparam int         BYTE_W     = 8;
    localparam logic [7:0] IDLE_BYTE  = 8'hFF;
    // Power-up answer block
    localparam logic [7:0] PU_COUNT   = 8'h04;
    localparam logic [5:0] PU_LEN     = 6'h04;
    localparam logic [7:0] PU_STATUS  = 8'h11;
    // Check bytes of the power-up block; arbitrary, the executor normally supplies them
    localparam logic [7:0] PU_CRC_LO  = 8'h00;
    localparam logic [7:0] PU_CRC_HI  = 8'h00;
    localparam logic [OUT_BYTES-1:0][7:0] PU_BUF =
        {{(8*(OUT_BYTES-4)){1'b0}}, PU_CRC_HI, PU_CRC_LO, PU_STATUS, PU_COUNT};
    // Wake timing at 25 MHz
    localparam int CLK_PERIOD_NS    = 40;
    localparam int WAKE_LOW_NS      = 60_000;
    localparam int WAKE_HIGH_NS     = 2_500_000;
    localparam int WAKE_LOW_CYCLES  = (WAKE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_HIGH_CYCLES = (WAKE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CNT_W       = 17;

    typedef enum logic [1:0] {MODE_AWAKE, MODE_BUSY, MODE_LOW, MODE_WAKE_HIGH} mode_t;
    typedef enum logic [2:0] {B_IDLE, B_RX, B_ACK, B_TX, B_MACK, B_WAIT} bus_t;
endpackage : i2c_port_pkg

// *** byte_fifo.sv ***
// Small synchronous FIFO between the bus side and the command executor
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             inValid,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  inReady,
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 fill;
    } fifo_t;

    fifo_t fifo_reg;
    fifo_t fifo_next;
    logic  push;
    logic  pop;

    assign inReady  = (fifo_reg.fill != (AW+1)'(DEPTH));
    assign outValid = (fifo_reg.fill != '0);
    assign outData  = fifo_reg.mem[fifo_reg.rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        fifo_next = fifo_reg;
        if (push) begin
            fifo_next.mem[fifo_reg.wrPtr] = inData;
            fifo_next.wrPtr = (fifo_reg.wrPtr == AW'(DEPTH-1)) ? '0 : fifo_reg.wrPtr + 1'b1;
        end
        if (pop) begin
            fifo_next.rdPtr = (fifo_reg.rdPtr == AW'(DEPTH-1)) ? '0 : fifo_reg.rdPtr + 1'b1;
        end
        fifo_next.fill = fifo_reg.fill + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fifo_reg <= '0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end

    fill_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
        fifo_reg.fill <= (AW+1)'(DEPTH)) else $error("fifo fill above depth");
endmodule : byte_fifo
`default_nettype wire

// *** i2c_packet_port.sv ***
// I2C slave packet port: word-address functions, input count, answer buffer and wake
`timescale 1ns/100ps
`default_nettype none
module i2c_packet_port
    import i2c_port_pkg::*;
#(
    parameter int WAKE_HIGH_CNT = WAKE_HIGH_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output logic            sdaOut,
    output logic            sdaOe,
    input  wire logic [7:0] deviceSelect,
    output logic      [7:0] cmdData,
    output logic            cmdValid,
    input  wire logic       cmdReady,
    output logic            cmdStart,
    output logic            cmdAbort,
    input  wire logic       resWe,
    input  wire logic [7:0] resData,
    input  wire logic       execDone,
    output logic            busy,
    output logic            lowPower,
    output logic            volatileClear
);
    typedef struct packed {
        mode_t                       mode;
        bus_t                        bus;
        logic [3:0]                  bitCnt;
        logic [7:0]                  sh;
        logic                        rxIsAddr;
        logic                        isRead;
        logic                        firstByte;
        logic [7:0]                  wordAddr;
        logic [6:0]                  inCount;
        logic [7:0]                  declCount;
        logic [5:0]                  outPtr;
        logic [5:0]                  outLen;
        logic [5:0]                  resPtr;
        logic [OUT_BYTES-1:0][7:0]   outBuf;
        logic                        partialRd;
        logic                        readFlag;
        logic                        pendLow;
        logic                        pendKeep;
        logic                        masterAck;
        logic [WAKE_CNT_W-1:0]       wakeCnt;
        logic                        sdaOe;
        logic                        sclPrev;
        logic                        sdaPrev;
        logic                        cmdStart;
        logic                        cmdAbort;
        logic                        volatileClear;
    } port_t;

    port_t port_reg;
    port_t port_next;
    logic  pushNow;
    logic  fifoReady;
    logic  wordResetHit;
    logic  sclRise;
    logic  sclFall;
    logic  startCond;
    logic  stopCond;
    logic  ack;
    logic  loadNext;
    logic  [7:0] txByte;

    // Answer byte at the counter, or all ones past the valid end or during a partial read
    function automatic logic [7:0] answerByte(port_t s);
        if (s.partialRd || (s.outPtr >= s.outLen)) begin
            return IDLE_BYTE;
        end
        return s.outBuf[s.outPtr];
    endfunction : answerByte

    assign sclRise   = sclIn && !port_reg.sclPrev;
    assign sclFall   = !sclIn && port_reg.sclPrev;
    assign startCond = sclIn && port_reg.sclPrev && port_reg.sdaPrev && !sdaIn;
    assign stopCond  = sclIn && port_reg.sclPrev && !port_reg.sdaPrev && sdaIn;

    always_comb begin
        port_next = port_reg;
        pushNow = 1'b0;
        wordResetHit = 1'b0;
        ack = 1'b0;
        loadNext = 1'b0;
        txByte = answerByte(port_reg);
        port_next.sclPrev = sclIn;
        port_next.sdaPrev = sdaIn;
        port_next.cmdStart = 1'b0;
        port_next.cmdAbort = 1'b0;
        port_next.volatileClear = 1'b0;
        unique case (port_reg.mode)
            MODE_LOW: begin
                port_next.bus = B_IDLE;
                port_next.sdaOe = 1'b0;
                if (!sdaIn) begin
                    if (port_reg.wakeCnt != '1) begin
                        port_next.wakeCnt = port_reg.wakeCnt + 1'b1;
                    end
                end else if (port_reg.wakeCnt >= WAKE_CNT_W'(WAKE_LOW_CYCLES)) begin
                    port_next.mode = MODE_WAKE_HIGH;
                    port_next.wakeCnt = '0;
                end else begin
                    port_next.wakeCnt = '0;
                end
            end
            MODE_WAKE_HIGH: begin
                if (port_reg.wakeCnt >= WAKE_CNT_W'(WAKE_HIGH_CNT - 1)) begin
                    port_next.mode = MODE_AWAKE;
                    port_next.wakeCnt = '0;
                    port_next.bus = B_IDLE;
                end else begin
                    port_next.wakeCnt = port_reg.wakeCnt + 1'b1;
                end
            end
            MODE_AWAKE, MODE_BUSY: begin
                if (startCond) begin
                    port_next.bus = B_RX;
                    port_next.rxIsAddr = 1'b1;
                    port_next.bitCnt = '0;
                    port_next.sdaOe = 1'b0;
                end else if (stopCond) begin
                    port_next.bus = B_IDLE;
                    port_next.sdaOe = 1'b0;
                    if (port_reg.pendLow) begin
                        port_next.pendLow = 1'b0;
                        port_next.mode = MODE_LOW;
                        port_next.wakeCnt = '0;
                        if (!port_reg.pendKeep) begin
                            port_next.outBuf = PU_BUF;
                            port_next.outLen = PU_LEN;
                            port_next.outPtr = '0;
                            port_next.inCount = '0;
                            port_next.readFlag = 1'b0;
                            port_next.volatileClear = 1'b1;
                            port_next.cmdAbort = (port_reg.inCount != '0);
                        end
                    end else if (port_reg.mode == MODE_AWAKE && port_reg.inCount != '0
                                 && {1'b0, port_reg.inCount} >= port_reg.declCount) begin
                        port_next.mode = MODE_BUSY;
                        port_next.cmdStart = 1'b1;
                        port_next.resPtr = '0;
                    end
                end else begin
                    unique case (port_reg.bus)
                        B_IDLE, B_WAIT: begin
                        end
                        B_RX: begin
                            if (sclRise) begin
                                port_next.sh = {port_reg.sh[6:0], sdaIn};
                                port_next.bitCnt = port_reg.bitCnt + 1'b1;
                            end else if (sclFall && port_reg.bitCnt == 4'h8) begin
                                port_next.bitCnt = '0;
                                if (port_reg.rxIsAddr) begin
                                    port_next.rxIsAddr = 1'b0;
                                    // refuse unless awake and not busy
                                    ack = (port_reg.sh[7:1] == deviceSelect[7:1])
                                          && port_reg.mode == MODE_AWAKE;
                                    if (ack) begin
                                        port_next.isRead = port_reg.sh[0];
                                        if (port_reg.sh[0]) begin
                                            port_next.partialRd = (port_reg.inCount != '0);
                                        end else begin
                                            port_next.firstByte = 1'b1;
                                            if (port_reg.readFlag) begin
                                                port_next.outPtr = '0;
                                                port_next.readFlag = 1'b0;
                                            end
                                        end
                                    end
                                end else if (port_reg.firstByte) begin
                                    port_next.firstByte = 1'b0;
                                    port_next.wordAddr = port_reg.sh;
                                    ack = 1'b1;
                                    unique case (port_reg.sh)
                                        WA_RESET: begin
                                            wordResetHit = 1'b1;
                                            port_next.outPtr = '0;
                                            port_next.readFlag = 1'b0;
                                            port_next.inCount = '0;
                                            port_next.cmdAbort = (port_reg.inCount != '0);
                                        end
                                        WA_SLEEP: begin
                                            port_next.pendLow = 1'b1;
                                            port_next.pendKeep = 1'b0;
                                        end
                                        WA_IDLE: begin
                                            port_next.pendLow = 1'b1;
                                            port_next.pendKeep = 1'b1;
                                        end
                                        default: begin
                                        end
                                    endcase
                                end else if (port_reg.wordAddr == WA_COMMAND && fifoReady
                                             && port_reg.inCount < IN_LIMIT
                                             && (port_reg.inCount == '0
                                                 || {1'b0, port_reg.inCount}
                                                    < port_reg.declCount)) begin
                                    ack = 1'b1;
                                    pushNow = 1'b1;
                                    if (port_reg.inCount == '0) begin
                                        port_next.declCount = port_reg.sh;
                                    end
                                    port_next.inCount = port_reg.inCount + 1'b1;
                                end
                                port_next.sdaOe = ack;
                                port_next.bus = ack ? B_ACK : B_WAIT;
                            end
                        end
                        B_ACK: begin
                            if (sclFall) begin
                                port_next.sdaOe = 1'b0;
                                if (port_reg.isRead) begin
                                    loadNext = 1'b1;
                                end else begin
                                    port_next.bus = B_RX;
                                    port_next.bitCnt = '0;
                                end
                            end
                        end
                        B_TX: begin
                            if (sclFall) begin
                                if (port_reg.bitCnt == 4'h8) begin
                                    port_next.sdaOe = 1'b0;
                                    port_next.bus = B_MACK;
                                end else begin
                                    port_next.sh = {port_reg.sh[6:0], 1'b1};
                                    port_next.sdaOe = !port_reg.sh[6];
                                    port_next.bitCnt = port_reg.bitCnt + 1'b1;
                                end
                            end
                        end
                        B_MACK: begin
                            if (sclRise) begin
                                port_next.masterAck = !sdaIn;
                            end else if (sclFall) begin
                                if (port_reg.masterAck) begin
                                    loadNext = 1'b1;
                                end else begin
                                    port_next.bus = B_WAIT;
                                end
                            end
                        end
                    endcase
                end
                // next byte, counter stops at end
                if (loadNext) begin
                    port_next.sh = txByte;
                    port_next.sdaOe = !txByte[7];
                    port_next.bitCnt = 4'h1;
                    port_next.bus = B_TX;
                    port_next.readFlag = 1'b1;
                    if (!port_reg.partialRd && port_reg.outPtr < port_reg.outLen) begin
                        port_next.outPtr = port_reg.outPtr + 1'b1;
                    end
                end
                if (port_reg.mode == MODE_BUSY) begin
                    if (resWe && port_reg.resPtr < 6'(OUT_BYTES)) begin
                        port_next.outBuf[port_reg.resPtr] = resData;
                        port_next.resPtr = port_reg.resPtr + 1'b1;
                    end
                    if (execDone) begin
                        port_next.mode = MODE_AWAKE;
                        port_next.outLen = port_next.resPtr;
                        port_next.outPtr = '0;
                        port_next.inCount = '0;
                        port_next.readFlag = 1'b0;
                    end
                end
            end
        endcase
    end

    // power-up answer; device starts asleep until woken
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            port_reg <= '0;
            port_reg.mode <= MODE_LOW;
            port_reg.outBuf <= PU_BUF;
            port_reg.outLen <= PU_LEN;
            port_reg.sclPrev <= 1'b1;
            port_reg.sdaPrev <= 1'b1;
        end else begin
            port_reg <= port_next;
        end
    end

    // Full buffer refuses the byte, so the host sees back-pressure as a no-acknowledge
    byte_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .inValid  (pushNow),
        .inData   (port_reg.sh),
        .inReady  (fifoReady),
        .outValid (cmdValid),
        .outData  (cmdData),
        .outReady (cmdReady)
    );

    assign sdaOut        = 1'b0;
    assign sdaOe         = port_reg.sdaOe;
    assign cmdStart      = port_reg.cmdStart;
    assign cmdAbort      = port_reg.cmdAbort;
    assign busy          = (port_reg.mode == MODE_BUSY);
    assign lowPower      = (port_reg.mode == MODE_LOW) || (port_reg.mode == MODE_WAKE_HIGH);
    assign volatileClear = port_reg.volatileClear;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    quiet_not_awake_a: assert property (port_reg.mode != MODE_AWAKE |-> !sdaOe)
        else $error("pin driven while not awake");
    count_limit_a: assert property (pushNow |-> (port_reg.inCount == '0
        || {1'b0, port_reg.inCount} < port_reg.declCount)) else $error("byte past count taken");
    buffer_limit_a: assert property (pushNow |-> port_reg.inCount < IN_LIMIT)
        else $error("byte past buffer end taken");
    sleep_clear_a: assert property (volatileClear |-> lowPower
        && port_reg.outLen == PU_LEN && port_reg.inCount == '0) else $error("sleep kept state");
    no_wrap_a: assert property (port_reg.outPtr <= port_reg.outLen)
        else $error("answer counter passed end");
    powerup_block_a: assert property ($rose(rst_n) |-> port_reg.outLen == PU_LEN
        && port_reg.outBuf[1] == PU_STATUS) else $error("power-up block wrong");
    word_reset_a: assert property (wordResetHit |=> port_reg.outPtr == '0
        && port_reg.inCount == '0) else $error("word reset did not rewind");
    start_busy_a: assert property (cmdStart |-> busy ##1 busy)
        else $error("start without busy");
    partial_ones_a: assert property (port_reg.bus == B_TX && port_reg.partialRd
        |-> port_reg.sh == IDLE_BYTE) else $error("partial read not all ones");
    wake_path_a: assert property ($fell(lowPower) |-> $past(port_reg.mode)
        == MODE_WAKE_HIGH) else $error("woke without delay");

    cmd_start_c: cover property (cmdStart);
    exec_done_c: cover property (busy ##1 !busy);
    partial_read_c: cover property (port_reg.bus == B_TX && port_reg.partialRd);
    sleep_entry_c: cover property (volatileClear);
endmodule : i2c_packet_port
`default_nettype wire

// *** i2c_host_model.sv ***
// Bus master model: drives the clock line and pulls the data line low
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
    input  wire logic mclk,
    input  wire logic sdaWire,
    output logic      scl,
    output logic      sdaLow
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic hold(input logic c, input logic d);
        scl = c;
        sdaLow = ~d;
        repeat (4) @(negedge mclk);
    endtask : hold
    task automatic start();
        hold(1'b1, 1'b1);
        hold(1'b1, 1'b0);
        hold(1'b0, 1'b0);
    endtask : start
    task automatic stop();
        hold(1'b0, 1'b0);
        hold(1'b1, 1'b0);
        hold(1'b1, 1'b1);
    endtask : stop
    // Data only changes while the clock is low
    task automatic xfer(input logic [7:0] tx, input logic nak, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            hold(1'b0, tx[i]);
            hold(1'b1, tx[i]);
            rx[i] = sdaWire;
        end
        hold(1'b0, nak);
        hold(1'b1, nak);
        ack = ~sdaWire;
    endtask : xfer
    task automatic wake();
        sdaLow = 1'b1;
        repeat (1600) @(negedge mclk);
        sdaLow = 1'b0;
    endtask : wake
endmodule : i2c_host_model
`default_nettype wire

// *** tb_i2c_packet_port.sv ***
// Self-checking bench for the packet port
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_i2c_packet_port;
    import i2c_port_pkg::*;
    logic       mclk = 1'b0, rst_n = 1'b0, resWe = 1'b0, execDone = 1'b0, cmdReady = 1'b1;
    logic [7:0] popped [16];
    int         nClr = 0, nStart = 0, nAbort = 0, nPop = 0;
    logic [7:0] resData = 8'h00, cmdData;
    logic       scl, sdaLow, sdaOut, sdaOe, cmdValid, cmdStart, cmdAbort, busy, lowPower, vClr;
    int         failures = 0, samples_checked = 0;
    wire logic  sdaWire = ~sdaLow & (sdaOe ? sdaOut : 1'b1);
    always #20 mclk = ~mclk;
    // Pulse counters and executor-side byte log, sampled before the edge updates them
    always @(posedge mclk) begin
        if (vClr) nClr <= nClr + 1;
        if (cmdStart) nStart <= nStart + 1;
        if (cmdAbort) nAbort <= nAbort + 1;
        if (cmdValid && cmdReady && nPop < 16) begin
            popped[nPop] <= cmdData;
            nPop <= nPop + 1;
        end
    end
    i2c_host_model host (.mclk(mclk), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));
    i2c_packet_port #(.WAKE_HIGH_CNT(20)) dut (.mclk(mclk), .rst_n(rst_n), .sclIn(scl),
        .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .deviceSelect(8'hC8),
        .cmdData(cmdData), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdStart(cmdStart),
        .cmdAbort(cmdAbort), .resWe(resWe), .resData(resData), .execDone(execDone),
        .busy(busy), .lowPower(lowPower), .volatileClear(vClr));
    task automatic close_out();
        if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic sb(input logic [7:0] b, input logic expAck);
        logic [7:0] r;
        logic       a;
        host.xfer(b, 1'b1, r, a);
        `CHK(a, expAck)
    endtask : sb
    task automatic pkt(input logic [7:0] w);
        host.start();
        sb(8'hC8, 1'b1);
        sb(w, 1'b1);
    endtask : pkt
    // Reads six bytes; the last byte is refused by the master
    task automatic readSix(input logic [7:0] e [6]);
        logic [7:0] r;
        logic       a;
        host.start();
        sb(8'hC9, 1'b1);
        for (int i = 0; i < 6; i++) begin
            host.xfer(8'hFF, i == 5, r, a);
            `CHK(r, e[i])
        end
        host.stop();
    endtask : readSix
    task automatic rdRefused();
        host.start();
        sb(8'hC9, 1'b0);
        host.stop();
    endtask : rdRefused
    task automatic wakeUp();
        host.wake();
        for (int i = 0; i < 200 && lowPower !== 1'b0; i++) @(negedge mclk);
        `CHK(lowPower, 1'b0)
        if (lowPower !== 1'b0) close_out();
    endtask : wakeUp
    task automatic scnCommand();
        host.start();
        sb(8'hCA, 1'b0);
        host.stop();
        pkt(WA_COMMAND);
        sb(8'h03, 1'b1);
        sb(8'h11, 1'b1);
        host.stop();
        readSix('{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
        pkt(WA_COMMAND);
        sb(8'h22, 1'b1);
        sb(8'h33, 1'b0);
        host.stop();
        `CHK(busy, 1'b1)
        `CHK(nStart, 1)
        `CHK(nPop, 3)
        `CHK(({popped[0], popped[1], popped[2]}), 24'h03_1122)
        rdRefused();
        for (int i = 0; i < 5; i++) begin
            resWe = 1'b1;
            resData = 8'h05 + 8'(i * 8'h11);
            @(negedge mclk);
        end
        resWe = 1'b0;
        execDone = 1'b1;
        @(negedge mclk);
        execDone = 1'b0;
        readSix('{8'h05, 8'h16, 8'h27, 8'h38, 8'h49, 8'hFF});
        pkt(WA_COMMAND);
        sb(8'h05, 1'b1);
        host.stop();
        pkt(WA_RESET);
        host.stop();
        `CHK(nAbort, 1)
        `CHK(popped[3], 8'h05)
        readSix('{8'h05, 8'h16, 8'h27, 8'h38, 8'h49, 8'hFF});
    endtask : scnCommand
    // Idle keeps key state, sleep clears it and restores the power-up answer
    task automatic scnLowPower();
        int clr0;
        for (int k = 0; k < 2; k++) begin
            clr0 = nClr;
            pkt(k == 0 ? WA_IDLE : WA_SLEEP);
            host.stop();
            `CHK(lowPower, 1'b1)
            `CHK(nClr - clr0, k)
            rdRefused();
            wakeUp();
        end
        readSix('{PU_COUNT, PU_STATUS, PU_CRC_LO, PU_CRC_HI, 8'hFF, 8'hFF});
    endtask : scnLowPower
    // Stalled executor fills the buffer; the ninth byte is refused and resent later
    task automatic scnBackPressure();
        cmdReady = 1'b0;
        pkt(WA_COMMAND);
        for (int i = 0; i < 9; i++) sb(8'h0A + 8'(i), i < FIFO_DEPTH);
        host.stop();
        `CHK(busy, 1'b0)
        cmdReady = 1'b1;
        pkt(WA_COMMAND);
        sb(8'h12, 1'b1);
        sb(8'h13, 1'b1);
        host.stop();
        `CHK(busy, 1'b1)
        `CHK(nStart, 2)
        `CHK(nPop, 14)
        `CHK(({popped[4], popped[11], popped[12], popped[13]}), 32'h0A11_1213)
        execDone = 1'b1;
        @(negedge mclk);
        execDone = 1'b0;
        `CHK(busy, 1'b0)
    endtask : scnBackPressure
    initial begin
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        rdRefused();
        wakeUp();
        readSix('{PU_COUNT, PU_STATUS, PU_CRC_LO, PU_CRC_HI, 8'hFF, 8'hFF});
        scnCommand();
        scnLowPower();
        scnBackPressure();
        close_out();
    end
endmodule : tb_i2c_packet_port
`default_nettype wire
